// [rtl/flash_host_ctrl.sv]
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// apb controlled host for a parallel nor flash
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int pulse_cyc = reset_cyc
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic [addr_w-1:0] f_addr,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n,
  input wire logic [15:0] f_dq_i,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe,
  output logic byte_n,
  output logic reset_n,
  output logic protect_accel_input,
  input wire logic ready_busy_n
);
  // ***************************************************************
  // registers
  // ***************************************************************
  logic [addr_w-1:0] addr_q; // target byte or word address
  logic [15:0] wdata_q; // data for next write cycle
  logic [15:0] rdata_q; // last read value
  logic [2:0] pins_q; // byte mode, reset, write protect
  op_t op_q; // current operation
  logic busy_q; // operation in flight
  logic done_q; // sticky done, cleared by next go
  logic poll_q; // last polled inverted data bit
  logic tog_q; // toggle seen between the two reads of a poll
  logic [count_w-1:0] rst_cnt_q; // reset pulse timer
  logic pulse_q; // reset pulse active
  logic [15:0] prev_q; // previous poll read
  logic second_q; // second read of a poll pair
  logic wr_en;
  logic go;
  logic cyc_start;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  // apb answers in the access phase at once
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign go = wr_en && paddr == ctrl_off && pwdata[ctrl_go_bit] && !busy_q;
  // unmapped addresses answer with error
  assign pslverr = psel && penable && !(paddr == ctrl_off ||
    paddr == addr_off || paddr == wdata_off || paddr == rdata_off ||
    paddr == status_off || paddr == pins_off);
  // ***************************************************************
  // software writes
  // ***************************************************************
  // address and data used by command sequence writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else if (wr_en && !busy_q) begin
      if (paddr == addr_off) begin
        addr_q <= pwdata[addr_w-1:0]; // R1
      end
      if (paddr == wdata_off) begin
        wdata_q <= pwdata[15:0];
      end
    end
  end
  // pin levels: word mode, reset released, write protect off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 3'h7;
    end else if (wr_en && paddr == pins_off) begin
      pins_q <= pwdata[2:0];
    end
  end
  // byte_n low selects the 8 bit bus on models with it R2
  assign byte_n = pins_q[pins_byte_bit];
  // wp low protects the boot sector R14
  assign protect_accel_input = pins_q[pins_wp_bit];
  // ***************************************************************
  // operation sequencer
  // ***************************************************************
  // one pin cycle per go, two for poll and none for reset pulse; software sequences the unlock cycles,
  // so two writes serve bypass programs and four normal ones R5
  // password words go out as plain write cycles the same way R9
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= op_read;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (go) begin
      op_q <= op_t'(pwdata[ctrl_op_hi:ctrl_op_lo]);
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      if (op_q == op_reset_pulse) begin
        if (pulse_q && rst_cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (op_q == op_poll) begin
        if (cyc_done && second_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (cyc_done) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
  // poll does two reads so a toggling bit can be seen R4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_q <= 1'b0;
    end else if (go) begin
      second_q <= 1'b0;
    end else if (cyc_done && op_q == op_poll) begin
      second_q <= !second_q;
    end
  end
  assign cyc_start = busy_q && op_q != op_reset_pulse &&
    !cyc_done && !(op_q == op_poll && second_q && cyc_done);
  // read results and poll status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= erased_word;
      prev_q <= erased_word;
      poll_q <= 1'b0;
      tog_q <= 1'b0;
    end else if (cyc_done && op_q != op_write) begin
      rdata_q <= cyc_rdata;
      prev_q <= cyc_rdata;
      if (op_q == op_poll && second_q) begin
        poll_q <= cyc_rdata[poll_bit]; // R4
        tog_q <= cyc_rdata[tog_bit] ^ prev_q[tog_bit]; // R4
      end
    end
  end
  // ***************************************************************
  // hardware reset pulse
  // ***************************************************************
  // held low long enough to abort any device operation R12
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (go && pwdata[ctrl_op_hi:ctrl_op_lo] == op_reset_pulse) begin
      pulse_q <= 1'b1;
      rst_cnt_q <= count_w'(pulse_cyc);
    end else if (pulse_q) begin
      if (rst_cnt_q == '0) begin
        pulse_q <= 1'b0;
      end else begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end
    end
  end
  assign reset_n = pins_q[pins_reset_bit] && !pulse_q; // R12
  // ***************************************************************
  // pin cycle engine
  // ***************************************************************
  // chip select released between cycles lets the device idle R13
  flash_pin_cycle #(
    .hold_cyc(strobe_cyc)
  ) flash_pin_cycle_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_write(op_q == op_write),
    .addr_in(addr_q),
    .wdata_in(wdata_q),
    .done(cyc_done),
    .rdata_out(cyc_rdata),
    .f_addr(f_addr),
    .f_ce_n(f_ce_n),
    .f_we_n(f_we_n),
    .f_oe_n(f_oe_n),
    .f_dq_i(f_dq_i),
    .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe)
  );
  // ***************************************************************
  // read mux
  // ***************************************************************
  always_comb begin
    prdata = '0;
    unique case (paddr)
      ctrl_off: prdata = {28'h0000000, op_q, busy_q};
      addr_off: prdata = {9'h000, addr_q};
      wdata_off: prdata = {16'h0000, wdata_q};
      rdata_off: prdata = {16'h0000, rdata_q};
      status_off: prdata = {27'h0000000, done_q, tog_q, poll_q,
                            ready_busy_n, busy_q};
      pins_off: prdata = {29'h00000000, pins_q};
      default: prdata = '0;
    endcase
  end
endmodule

// [rtl/flash_host_pkg.sv]
// What the flash device does
// [R1] array holds 4M words or 8M bytes
// [R2] width select picks 16 or 8 bit bus
// [R3] each write strobe latches address and data
// [R4] completion found by poll bits or ready
// [R5] unlock bypass program needs two writes
// [R6] sector erase leaves other sectors intact
// [R7] low supply blocks all writes
// [R8] protected sectors reject program and erase
// [R9] password needed before protection changes
// [R10] erase suspend allows other sector access
// [R11] program suspend allows other sector reads
// [R12] reset pin aborts and readies device
// [R13] standby on idle select or stable address
// [R14] write protect low guards boot sector
// [R15] secure region 128 words, lock permanent
// [R16] serial number reached by command sequence
// [R17] reads served from eight word page
// [R18] write buffer takes up to 128 words
// [R19] sector counts per uniform or boot model
// [R20] single bit errors corrected internally
// [R21] delivered fully erased
// [R22] erased reads ones, program clears bits
package flash_host_pkg;
  // ***************************************************************
  // apb register map of the controller
  // ***************************************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] addr_off = 8'h04;
  localparam logic [7:0] wdata_off = 8'h08;
  localparam logic [7:0] rdata_off = 8'h0C;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] pins_off = 8'h14;
  // ctrl and pins field positions
  localparam int ctrl_go_bit = 0;
  localparam int ctrl_op_lo = 1;
  localparam int ctrl_op_hi = 3;
  localparam int pins_byte_bit = 0;
  localparam int pins_reset_bit = 1;
  localparam int pins_wp_bit = 2;
  // status field positions
  localparam int st_busy_bit = 0;
  localparam int st_rdy_bit = 1;
  localparam int st_poll_bit = 2;
  localparam int st_tog_bit = 3;
  localparam int st_done_bit = 4;
  // ***************************************************************
  // bus geometry and data patterns
  // ***************************************************************
  localparam int addr_w = 23; // byte address of 8m bytes
  localparam int word_addr_w = 22; // 4m words
  localparam logic [15:0] erased_word = 16'hFFFF;
  localparam int poll_bit = 7; // inverted_data_poll_bit
  localparam int tog_bit = 6; // toggling_status_bit
  // ***************************************************************
  // timing at 50 mhz
  // ***************************************************************
  localparam int clk_ns = 20;
  localparam int access_ns = 70;
  localparam int strobe_cyc = (access_ns + clk_ns - 1) / clk_ns;
  localparam int reset_pulse_ns = 500;
  localparam int reset_cyc = (reset_pulse_ns + clk_ns - 1) / clk_ns;
  localparam int count_w = 8;
  // bus cycle kinds of the pin sequencer
  typedef enum logic [1:0] {cyc_read, cyc_write} cyc_t;
  // operations that software starts
  typedef enum logic [2:0] {
    op_read, op_write, op_poll, op_reset_pulse
  } op_t;
endpackage

// [rtl/flash_pin_cycle.sv]
`timescale 1ns/100ps
// one asynchronous bus cycle on the flash pins
module flash_pin_cycle
  import flash_host_pkg::*;
#(
  parameter int hold_cyc = strobe_cyc
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  input wire logic start,
  input wire logic is_write,
  input wire logic [addr_w-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic done,
  output logic [15:0] rdata_out,
  // flash pins
  output logic [addr_w-1:0] f_addr,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n,
  input wire logic [15:0] f_dq_i,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe
);
  // ***************************************************************
  // strobe timer
  // ***************************************************************
  logic [count_w-1:0] cnt_q;
  logic active_q;
  logic wr_q;
  // strobe held for whole access time, then released for at least one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      active_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (start && !active_q) begin
      active_q <= 1'b1;
      wr_q <= is_write;
      cnt_q <= count_w'(hold_cyc);
    end else if (active_q) begin
      if (cnt_q == '0) begin
        active_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // pins registered so strobes stay glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_addr <= '0;
      f_dq_o <= '0;
      f_dq_oe <= 1'b0;
      f_ce_n <= 1'b1;
      f_we_n <= 1'b1;
      f_oe_n <= 1'b1;
    end else if (start && !active_q) begin
      f_addr <= addr_in;
      f_dq_o <= wdata_in;
      f_dq_oe <= is_write;
      f_ce_n <= 1'b0;
      f_we_n <= !is_write; // R3
      f_oe_n <= is_write;
    end else if (active_q && cnt_q == '0) begin
      f_ce_n <= 1'b1;
      f_we_n <= 1'b1; // rising we latches data R3
      f_oe_n <= 1'b1;
      f_dq_oe <= 1'b0;
    end
  end
  // read data sampled on the last strobe cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_out <= '0;
    end else if (active_q && cnt_q == '0 && !wr_q) begin
      rdata_out <= f_dq_i;
    end
  end
  // done follows the capture edge, so rdata_out already holds the word
  // when the sequencer takes it; a combinational done handed on stale data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= active_q && cnt_q == '0;
    end
  end
endmodule

// [tb/flash_host_asserts.sv]
`timescale 1ns/100ps
// ****************************************
// pin and bus checks on the host controller
// ****************************************
module flash_host_asserts
  import flash_host_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flash pins
  input wire logic [addr_w-1:0] f_addr,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic [15:0] f_dq_o,
  input wire logic f_dq_oe,
  input wire logic byte_n,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a read and a write strobe together would fight on the data bus
  a_strobe_excl: assert property (!(!f_we_n && !f_oe_n))
    else $error("write and output strobes low together");
  a_we_len: assert property ($fell(f_we_n) |-> !f_we_n[*5] ##1 f_we_n)
    else $error("write strobe width wrong");
  a_oe_len: assert property ($fell(f_oe_n) |-> !f_oe_n[*5] ##1 f_oe_n)
    else $error("read strobe width wrong");
  a_dq_drive: assert property (!f_we_n |-> f_dq_oe && !f_ce_n)
    else $error("write strobe without driven data");
  a_addr_hold: assert property ($fell(f_ce_n) |=> $stable(f_addr)[*4])
    else $error("address moved within strobe");
  a_data_hold: assert property ($fell(f_we_n) |=> $stable(f_dq_o)[*4])
    else $error("write data moved within strobe");
  a_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  a_ready_seen: assert property (psel && penable && !pwrite
    && paddr == status_off |-> prdata[st_rdy_bit] == ready_busy_n)
    else $error("ready level not shown in status");
  a_pins_shown: assert property (psel && penable && !pwrite
    && paddr == pins_off |-> prdata[pins_byte_bit] == byte_n)
    else $error("byte width pin not shown in pins register");
  a_ce_idle: assert property (f_we_n && f_oe_n |-> f_ce_n)
    else $error("chip select held with no strobe low");
  // main scenarios reached
  c_write: cover property ($fell(f_we_n));
  c_read: cover property ($fell(f_oe_n));
  c_busy: cover property ($fell(ready_busy_n));
endmodule
bind flash_host_ctrl flash_host_asserts flash_host_asserts_inst (.*);

// [tb/flash_host_ctrl_tb.sv]
`timescale 1ns/100ps
// ****************************************
// apb driven test of the flash host
// ****************************************
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [addr_w-1:0] f_addr;
  logic f_ce_n, f_we_n, f_oe_n, f_dq_oe, byte_n, reset_n;
  logic protect_accel_input, ready_busy_n;
  logic [15:0] f_dq_i, f_dq_o;
  int bad_count, checked;
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  flash_host_ctrl #(.pulse_cyc(2)) flash_host_ctrl_inst (.*);
  flash_model flash_model_inst (.*);
  task summarize;
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // one apb transfer, held until pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken where settled, just before the sampling edge
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    q = prdata;
    perr = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask
  // start one pin operation and wait until it is no longer busy
  task op(input op_t o, input logic [3:0] a, input logic [15:0] d);
    int n;
    xfer(1, addr_off, {28'h0000000, a});
    xfer(1, wdata_off, {16'h0000, d});
    xfer(1, ctrl_off, {28'h0000000, o, 1'b1});
    n = 0;
    do begin
      xfer(0, status_off, 0);
      n++;
    end while (q[st_busy_bit] !== 1'b0 && n < 50);
    chk(q[st_done_bit], 1'b1);
  endtask
  task pgm(input logic [3:0] a, input logic [15:0] d);
    int n;
    op(op_write, a, 16'h00A0);
    op(op_write, a, d);
    n = 0;
    do begin
      xfer(0, status_off, 0);
      n++;
    end while (q[st_rdy_bit] !== 1'b1 && n < 100);
    chk(q[st_rdy_bit], 1'b1);
  endtask
  task rdw(input logic [3:0] a);
    op(op_read, a, 0);
    xfer(0, rdata_off, 0);
  endtask
  // watchdog well beyond the several hundred cycles needed
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    presetn = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, pins_off, 0);
    chk(q, 32'h00000007);
    xfer(1, addr_off, 32'hFFFFFFFF);
    xfer(0, addr_off, 0);
    chk(q, 32'h007FFFFF);
    rdw(4'h3);
    chk(q[15:0], erased_word);
    op(op_write, 4'h2, 16'h00A0);
    op(op_write, 4'h2, 16'h12F4);
    op(op_poll, 4'h2, 0);
    chk(q[3:1], 3'b100);
    pgm(4'h5, 16'h0000);
    op(op_poll, 4'h2, 0);
    chk(q[3:1], 3'b011);
    rdw(4'h2);
    chk(q[15:0], 16'h12F4);
    pgm(4'h2, 16'hFF0F);
    rdw(4'h2);
    chk(q[15:0], 16'h1204);
    rdw(4'h3);
    chk(q[15:0], erased_word);
    pgm(4'h1, 16'h0000);
    rdw(4'h1);
    chk(q[15:0], erased_word);
    xfer(1, pins_off, 32'h00000002);
    @(negedge pclk);
    chk({protect_accel_input, byte_n}, 2'b00);
    pgm(4'h0, 16'h0000);
    xfer(1, pins_off, 32'h00000007);
    rdw(4'h0);
    chk(q[15:0], erased_word);
    op(op_write, 4'h4, 16'h00A0);
    op(op_write, 4'h4, 16'h0000);
    op(op_reset_pulse, 4'h0, 0);
    chk(q[st_rdy_bit], 1'b1);
    rdw(4'h4);
    chk(q[15:0], erased_word);
    xfer(0, 8'h20, 0);
    chk(perr, 1'b1);
    summarize;
  end
endmodule

// [tb/flash_model.sv]
`timescale 1ns/100ps
// ****************************************
// behavioural flash, sixteen words deep
// ****************************************
module flash_model
  import flash_host_pkg::*;
(
  // clock paces the busy time, the supply ramp and strobe sampling
  input wire logic pclk,
  // bus pins
  input wire logic [addr_w-1:0] f_addr,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic [15:0] f_dq_o,
  output logic [15:0] f_dq_i,
  // control pins
  input wire logic byte_n,
  input wire logic reset_n,
  input wire logic protect_accel_input,
  output logic ready_busy_n
);
  logic [15:0] mem [16]; // tiny array, low address bits only
  logic [15:0] pend_d, last;
  logic [3:0] pend_a;
  logic armed, tog, we_q, oe_q;
  int busy, ramp; // ramp counts down while the supply settles
  // word 1 stands for a sector under sector protection
  localparam logic [15:0] locked = 16'h0002;
  initial begin
    foreach (mem[i]) mem[i] = erased_word;
    {busy, armed, tog, last} = 0;
    {we_q, oe_q} = 2'b11;
    ramp = 8;
  end
  // command capture, busy count and array update
  always @(posedge pclk) begin
    we_q <= f_we_n;
    oe_q <= f_oe_n;
    if (ramp > 0) ramp <= ramp - 1;
    if (!f_oe_n) last <= f_dq_i;
    if (!reset_n) begin
      busy <= 0;
      armed <= 0;
    end else if (!f_we_n && we_q && !f_ce_n && ramp == 0) begin
      // second write after setup word starts a 60 cycle program
      if (armed && busy == 0) begin
        pend_a <= f_addr[3:0];
        pend_d <= f_dq_o;
        busy <= 60;
      end
      armed <= f_dq_o == 16'h00A0 && !armed;
    end else if (busy == 1) begin
      // word 0 stands for the guarded boot sector
      if ((protect_accel_input || pend_a != 4'h0) && !locked[pend_a])
        mem[pend_a] <= mem[pend_a] & pend_d;
      busy <= 0;
    end else if (busy > 1) begin
      busy <= busy - 1;
    end
    if (!f_oe_n && oe_q) tog <= ~tog;
  end
  assign ready_busy_n = busy == 0;
  // released bus shows the inverse of the last value
  assign f_dq_i = (f_oe_n || f_ce_n) ? ~last
    : busy != 0 ? {8'h00, ~pend_d[7], tog, 6'h00} : mem[f_addr[3:0]];
endmodule
